// *** rtl/cgr_pkg.sv ***
// cgr_pkg: offsets, field layout, reset values and spread encodings of the id/count register bank
// assumes: byte-wide register access from a serial management front end
package cgr_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_SPREAD = 8'h01;
  localparam logic [7:0] OFS_RSVD = 8'h04;
  localparam logic [7:0] OFS_REV_VENDOR = 8'h05;
  localparam logic [7:0] OFS_PART_TYPE = 8'h06;
  localparam logic [7:0] OFS_RD_LEN = 8'h07;
  localparam int SPR_EN_BIT = 5;
  localparam int SPR_AMT_HI = 4;
  localparam int SPR_AMT_LO = 3;
  localparam int REV_HI = 7;
  localparam int REV_LO = 4;
  localparam int MAKER_HI = 3;
  localparam int MAKER_LO = 0;
  localparam int CLASS_HI = 7;
  localparam int CLASS_LO = 6;
  localparam int PNUM_HI = 5;
  localparam int PNUM_LO = 0;
  localparam int LEN_HI = 4;
  localparam int LEN_LO = 0;
  localparam logic [4:0] RD_LEN_RST = 5'h08;
  localparam logic [7:0] RSVD_VAL = 8'h00;
  localparam logic [1:0] AMT_RST = 2'h0;
  typedef enum logic [1:0] {
    CGR_SPREAD_OFF,
    CGR_SPREAD_025,
    CGR_SPREAD_RSVD,
    CGR_SPREAD_050
  } cgr_spread_t;
endpackage

// *** rtl/cgr_spread_sel.sv ***
// cgr_spread_sel: decodes the software spread amount into the spread mode
// assumes: enable and amount come from registers on the same clock
`timescale 1ns/1ns
module cgr_spread_sel (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sw_enable,
  input wire logic [1:0] amount,
  input wire cgr_pkg::cgr_spread_t pin_mode,
  output cgr_pkg::cgr_spread_t mode_r
);
  cgr_pkg::cgr_spread_t mode_nxt;

  always_comb begin
    mode_nxt = pin_mode;
    if (sw_enable) begin
      case (amount)
        2'h0: mode_nxt = cgr_pkg::CGR_SPREAD_OFF;
        2'h1: mode_nxt = cgr_pkg::CGR_SPREAD_025;
        2'h2: mode_nxt = cgr_pkg::CGR_SPREAD_RSVD;
        2'h3: mode_nxt = cgr_pkg::CGR_SPREAD_050;
        default: mode_nxt = cgr_pkg::CGR_SPREAD_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= cgr_pkg::CGR_SPREAD_OFF;
    end else begin
      mode_r <= mode_nxt;
    end
  end
endmodule // cgr_spread_sel

// *** rtl/cgr_regs.sv ***
// cgr_regs: identification, block-read length and software spread registers
// assumes: serial front end gives one-cycle write/read strobes with byte address
`timescale 1ns/1ns
// How it works
// - amount bits are ignored unless the software spread enable bit is one.
// - amount 00 off, 01 minus 0.25 percent, 10 reserved, 11 minus 0.5 percent.
// - byte 5 read-only: revision code bits 7-4, maker code bits 3-0.
// - byte 6 read-only: part class bits 7-6, part number code bits 5-0.
// - byte 7 holds writable five-bit length; upper three bits reserved.
// - length sets bytes returned in a block read; resets to eight.
module cgr_regs #(
  parameter logic [3:0] REV_CODE = 4'h3,   // arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'h5, // arbitrary value
  parameter logic [1:0] PART_CLASS = 2'h1, // arbitrary value
  parameter logic [5:0] PART_NUM = 6'h11   // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire cgr_pkg::cgr_spread_t pin_mode,
  output logic [7:0] rdata_r,
  output logic [4:0] rd_len_r,
  output logic sw_enable_r,
  output logic [1:0] amount_r,
  output cgr_pkg::cgr_spread_t mode_r
);
  logic [7:0] rdata_nxt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_len_r <= cgr_pkg::RD_LEN_RST;
    end else if (wr_en && addr == cgr_pkg::OFS_RD_LEN) begin
      rd_len_r <= wdata[cgr_pkg::LEN_HI:cgr_pkg::LEN_LO];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_enable_r <= 1'h0;
      amount_r <= cgr_pkg::AMT_RST;
    end else if (wr_en && addr == cgr_pkg::OFS_SPREAD) begin
      sw_enable_r <= wdata[cgr_pkg::SPR_EN_BIT];
      amount_r <= wdata[cgr_pkg::SPR_AMT_HI:cgr_pkg::SPR_AMT_LO];
    end
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_en) begin
      case (addr)
        cgr_pkg::OFS_SPREAD: rdata_nxt = {2'h0, sw_enable_r, amount_r, 3'h0};
        cgr_pkg::OFS_RSVD: rdata_nxt = cgr_pkg::RSVD_VAL;
        cgr_pkg::OFS_REV_VENDOR: rdata_nxt = {REV_CODE, MAKER_CODE};
        cgr_pkg::OFS_PART_TYPE: rdata_nxt = {PART_CLASS, PART_NUM};
        cgr_pkg::OFS_RD_LEN: rdata_nxt = {3'h0, rd_len_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  cgr_spread_sel i_cgr_spread_sel (
    .clk(clk),
    .rst_b(rst_b),
    .sw_enable(sw_enable_r),
    .amount(amount_r),
    .pin_mode(pin_mode),
    .mode_r(mode_r)
  );

  property p_len_write;
    @(posedge clk) disable iff (!rst_b)
    wr_en && addr == cgr_pkg::OFS_RD_LEN |=> rd_len_r == $past(wdata[cgr_pkg::LEN_HI:cgr_pkg::LEN_LO]);
  endproperty
  a_len_write: assert property (p_len_write) else $error("length not written");

  property p_len_hold;
    @(posedge clk) disable iff (!rst_b)
    !(wr_en && addr == cgr_pkg::OFS_RD_LEN) |=> $stable(rd_len_r);
  endproperty
  a_len_hold: assert property (p_len_hold) else $error("length changed without write");

  property p_rsvd_zero;
    @(posedge clk) disable iff (!rst_b)
    rd_en && addr == cgr_pkg::OFS_RSVD |=> rdata_r == cgr_pkg::RSVD_VAL;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved byte not zero");

  property p_rev;
    @(posedge clk) disable iff (!rst_b)
    rd_en && addr == cgr_pkg::OFS_REV_VENDOR |=> rdata_r == {REV_CODE, MAKER_CODE};
  endproperty
  a_rev: assert property (p_rev) else $error("revision byte wrong");

  property p_part;
    @(posedge clk) disable iff (!rst_b)
    rd_en && addr == cgr_pkg::OFS_PART_TYPE |=> rdata_r == {PART_CLASS, PART_NUM};
  endproperty
  a_part: assert property (p_part) else $error("part byte wrong");

  property p_len_read;
    @(posedge clk) disable iff (!rst_b)
    rd_en && addr == cgr_pkg::OFS_RD_LEN |=> rdata_r == {3'h0, $past(rd_len_r)};
  endproperty
  a_len_read: assert property (p_len_read) else $error("length readback wrong");

  property p_sw_off;
    @(posedge clk) disable iff (!rst_b)
    rst_b && !sw_enable_r |=> mode_r == $past(pin_mode);
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("amount used while disabled");

  property p_sw_half;
    @(posedge clk) disable iff (!rst_b)
    sw_enable_r && amount_r == 2'h3 |=> mode_r == cgr_pkg::CGR_SPREAD_050;
  endproperty
  a_sw_half: assert property (p_sw_half) else $error("amount 11 not half percent");

  property p_sw_quarter;
    @(posedge clk) disable iff (!rst_b)
    sw_enable_r && amount_r == 2'h1 |=> mode_r == cgr_pkg::CGR_SPREAD_025;
  endproperty
  a_sw_quarter: assert property (p_sw_quarter) else $error("amount 01 not quarter percent");

  c_len_wr: cover property (@(posedge clk) wr_en && addr == cgr_pkg::OFS_RD_LEN);
  c_sw_on: cover property (@(posedge clk) sw_enable_r && amount_r == 2'h3);
  c_id_rd: cover property (@(posedge clk) rd_en && addr == cgr_pkg::OFS_REV_VENDOR);
  c_sw_pin: cover property (@(posedge clk) rst_b && !sw_enable_r && amount_r == 2'h3);
  c_rst_held: cover property (@(posedge clk) !rst_b ##1 !rst_b);

  property p_len_rst;
    @(posedge clk)
    !rst_b ##1 !rst_b |-> rd_len_r == cgr_pkg::RD_LEN_RST;
  endproperty
  a_len_rst: assert property (p_len_rst) else $error("length not eight in reset");

  property p_len_upper;
    @(posedge clk) disable iff (!rst_b)
    rd_en && addr == cgr_pkg::OFS_RD_LEN |=> rdata_r[7:cgr_pkg::LEN_HI+1] == '0;
  endproperty
  a_len_upper: assert property (p_len_upper) else $error("length upper bits not zero");

  property p_len_stand;
    @(posedge clk) disable iff (!rst_b)
    rd_en && addr == cgr_pkg::OFS_RD_LEN ##1 !rd_en |=> $stable(rdata_r);
  endproperty
  a_len_stand: assert property (p_len_stand) else $error("length readback not held");

  property p_spread_wr;
    @(posedge clk) disable iff (!rst_b)
    wr_en && addr == cgr_pkg::OFS_SPREAD |=> sw_enable_r == $past(wdata[cgr_pkg::SPR_EN_BIT])
      && amount_r == $past(wdata[cgr_pkg::SPR_AMT_HI:cgr_pkg::SPR_AMT_LO]);
  endproperty
  a_spread_wr: assert property (p_spread_wr) else $error("spread bits not written");

  property p_spread_hold;
    @(posedge clk) disable iff (!rst_b)
    !(wr_en && addr == cgr_pkg::OFS_SPREAD) |=> $stable(sw_enable_r) && $stable(amount_r);
  endproperty
  a_spread_hold: assert property (p_spread_hold) else $error("spread bits changed without write");

  property p_spread_read;
    @(posedge clk) disable iff (!rst_b)
    rd_en && addr == cgr_pkg::OFS_SPREAD |=> rdata_r[cgr_pkg::SPR_EN_BIT] == $past(sw_enable_r)
      && rdata_r[cgr_pkg::SPR_AMT_HI:cgr_pkg::SPR_AMT_LO] == $past(amount_r);
  endproperty
  a_spread_read: assert property (p_spread_read) else $error("spread readback wrong");

  property p_sw_zero;
    @(posedge clk) disable iff (!rst_b)
    sw_enable_r && amount_r == 2'h0 |=> mode_r == cgr_pkg::CGR_SPREAD_OFF;
  endproperty
  a_sw_zero: assert property (p_sw_zero) else $error("amount 00 not off");

  property p_sw_rsvd;
    @(posedge clk) disable iff (!rst_b)
    sw_enable_r && amount_r == 2'h2 |=> mode_r == cgr_pkg::CGR_SPREAD_RSVD;
  endproperty
  a_sw_rsvd: assert property (p_sw_rsvd) else $error("amount 10 not reserved");

  property p_rsvd_wr;
    @(posedge clk) disable iff (!rst_b)
    wr_en && addr == cgr_pkg::OFS_RSVD |=> $stable(rd_len_r) && $stable(sw_enable_r) && $stable(amount_r);
  endproperty
  a_rsvd_wr: assert property (p_rsvd_wr) else $error("reserved byte write had effect");

  property p_rsvd_stand;
    @(posedge clk) disable iff (!rst_b)
    rd_en && addr == cgr_pkg::OFS_RSVD ##1 !rd_en |=> rdata_r == cgr_pkg::RSVD_VAL;
  endproperty
  a_rsvd_stand: assert property (p_rsvd_stand) else $error("reserved readback not held");

  property p_rev_wr;
    @(posedge clk) disable iff (!rst_b)
    wr_en && addr == cgr_pkg::OFS_REV_VENDOR |=> $stable(rd_len_r) && $stable(sw_enable_r) && $stable(amount_r);
  endproperty
  a_rev_wr: assert property (p_rev_wr) else $error("revision byte write had effect");

  property p_rev_stand;
    @(posedge clk) disable iff (!rst_b)
    rd_en && addr == cgr_pkg::OFS_REV_VENDOR ##1 !rd_en |=> rdata_r == {REV_CODE, MAKER_CODE};
  endproperty
  a_rev_stand: assert property (p_rev_stand) else $error("revision readback not held");

  property p_part_wr;
    @(posedge clk) disable iff (!rst_b)
    wr_en && addr == cgr_pkg::OFS_PART_TYPE |=> $stable(rd_len_r) && $stable(sw_enable_r) && $stable(amount_r);
  endproperty
  a_part_wr: assert property (p_part_wr) else $error("part byte write had effect");

  property p_part_stand;
    @(posedge clk) disable iff (!rst_b)
    rd_en && addr == cgr_pkg::OFS_PART_TYPE ##1 !rd_en |=> rdata_r == {PART_CLASS, PART_NUM};
  endproperty
  a_part_stand: assert property (p_part_stand) else $error("part readback not held");
endmodule // cgr_regs

// *** bench/cgr_host.sv ***
// cgr_host: management host model issuing one-cycle byte strobes
// assumes: design takes strobes on the rising clock edge
`timescale 1ns/1ns
module cgr_host (
  input wire logic clk,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata_r
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata_r;
  endtask
endmodule // cgr_host

// *** bench/clock_gen_id_and_count_regs_tb.sv ***
// clock_gen_id_and_count_regs_tb: register access sequences with expected values
// assumes: cgr_host drives the strobes
`timescale 1ns/1ns
module clock_gen_id_and_count_regs_tb;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata_r;
  logic [7:0] v;
  logic [4:0] rd_len_r;
  logic sw_enable_r;
  logic [1:0] amount_r;
  cgr_pkg::cgr_spread_t mode_r;
  cgr_pkg::cgr_spread_t pin_mode = cgr_pkg::CGR_SPREAD_RSVD;
  int n_fail = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  cgr_host i_cgr_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata_r(rdata_r));
  cgr_regs #(.REV_CODE(4'ha), .MAKER_CODE(4'h6), .PART_CLASS(2'h2), .PART_NUM(6'h2d)) i_cgr_regs (
    .clk(clk), .rst_b(rst_b), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .pin_mode(pin_mode), .rdata_r(rdata_r), .rd_len_r(rd_len_r), .sw_enable_r(sw_enable_r),
    .amount_r(amount_r), .mode_r(mode_r));
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    chk("len_rst", 8'h08, {3'h0, rd_len_r});
    @(posedge clk) rst_b <= 1'h1;
    for (int i = 4; i < 8; i++) i_cgr_host.wr(i[7:0], 8'hff);
    i_cgr_host.rd(8'h04, v);
    chk("byte4", 8'h00, v);
    i_cgr_host.rd(8'h05, v);
    chk("byte5", 8'ha6, v);
    i_cgr_host.rd(8'h06, v);
    chk("byte6", 8'had, v);
    i_cgr_host.rd(8'h07, v);
    chk("byte7", 8'h1f, v);
    i_cgr_host.rd(8'h09, v);
    chk("unmapped", 8'h00, v);
    i_cgr_host.wr(8'h07, 8'he3);
    #1;
    chk("len", 8'h03, {3'h0, rd_len_r});
    i_cgr_host.wr(8'h01, 8'h18);
    repeat (3) @(posedge clk);
    #1;
    chk("mode_off", 8'h02, {6'h0, mode_r});
    for (int a = 0; a < 4; a++) begin
      i_cgr_host.wr(8'h01, {3'h1, a[1:0], 3'h0});
      repeat (3) @(posedge clk);
      #1;
      chk("mode_sw", {6'h0, a[1:0]}, {6'h0, mode_r});
      chk("spread_reg", {5'h0, 1'h1, a[1:0]}, {5'h0, sw_enable_r, amount_r});
      i_cgr_host.rd(8'h01, v);
      chk("byte1", {3'h1, a[1:0], 3'h0}, v);
    end
    i_cgr_host.wr(8'h01, 8'h18);
    pin_mode <= cgr_pkg::CGR_SPREAD_025;
    repeat (3) @(posedge clk);
    #1;
    chk("mode_pin", 8'h01, {6'h0, mode_r});
    chk("spread_off", 8'h03, {5'h0, sw_enable_r, amount_r});
    @(posedge clk) rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk("len_rst2", 8'h08, {3'h0, rd_len_r});
    chk("spread_rst", 8'h00, {5'h0, sw_enable_r, amount_r});
    @(posedge clk) rst_b <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk("mode_rst", 8'h01, {6'h0, mode_r});
    end_sim();
  end
endmodule // clock_gen_id_and_count_regs_tb
